// File: hsse_defines.vh
// Constants for the half-space site evaluator: widths, site layout, setup states.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef HSSE_DEFINES_VH
`define HSSE_DEFINES_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define HSSE_COORD_W     16
`define HSSE_DIFF_W      17
`define HSSE_VAL_W       36
`define HSSE_SUM_W       37

// ----------------------------------------------------------------------------
// Site layout
// ----------------------------------------------------------------------------
`define HSSE_SITES       16
`define HSSE_AXIS        4
`define HSSE_IDX_W       4
`define HSSE_OFS_SHIFT   3
`define HSSE_STEP_FIRST  2'h1
`define HSSE_STEP_LAST   2'h3

// ----------------------------------------------------------------------------
// Setup sequencer states
// ----------------------------------------------------------------------------
`define HSSE_ST_IDLE     2'h0
`define HSSE_ST_BUILD    2'h1
`define HSSE_ST_LOAD     2'h2

`define HSSE_VAL_ZERO    36'h000000000

`endif

// File: hsse_site_cell.v
// One site cell: a site value register, an adder against the shared constant,
// and a registered sign bit. Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "hsse_defines.vh"

module hsse_site_cell (
  // Clock and reset
  input  wire                          mclk,
  input  wire                          rst,
  // Site value load
  input  wire                          load_en,
  input  wire signed [`HSSE_VAL_W-1:0] load_val,
  // Shared constant bus
  input  wire                          eval_en,
  input  wire signed [`HSSE_VAL_W-1:0] const_val,
  // Result
  output reg                           sign_out
);

  // --------------------------------------------------------------------------
  // Site value register
  // --------------------------------------------------------------------------
  reg  signed [`HSSE_VAL_W-1:0] site_reg;
  wire signed [`HSSE_SUM_W-1:0] sum_w;

  always @(posedge mclk) begin
    if (rst) begin
      site_reg <= `HSSE_VAL_ZERO;
    end else if (load_en) begin
      site_reg <= load_val;
    end
  end

  // --------------------------------------------------------------------------
  // Single add per update array, sign only
  // --------------------------------------------------------------------------
  // One guard bit keeps the sign right for any pair of operands
  assign sum_w = {site_reg[`HSSE_VAL_W-1], site_reg}
               + {const_val[`HSSE_VAL_W-1], const_val};

  always @(posedge mclk) begin
    if (rst) begin
      sign_out <= 1'b0;
    end else if (eval_en) begin
      sign_out <= sum_w[`HSSE_SUM_W-1];
    end
  end

endmodule // hsse_site_cell

`default_nettype wire

// File: hsse_evaluator.v
// Half-space evaluator: sixteen site cells over a 4x4 update array.
// Assumes the controller supplies site values (direct or via dx/dy setup)
// and the per-array constant; one clock, synchronous active-high reset.
//
// Summary of operation
// - All sixteen sides decided in one evaluation
// - Only sign of edge function is used
// - Site coordinate is origin plus fixed offset
// - Offsets per axis are 0, 8, 16, 24
// - Per site only one addition per array
// - Side is sign of site plus constant
// - One bus carries same constant to all
// - Each site register loaded per edge, held
// - Each cell adds and outputs sign only
// - Sixteen separate boolean side outputs
// - Coordinates are signed 16-bit subpixel values
// - Pixels sampled at subpixel corner (0,0)
`timescale 1ns/1ps
`default_nettype none
`include "hsse_defines.vh"

module hsse_evaluator (
  // Clock and reset
  input  wire                          mclk,
  input  wire                          rst,
  // Direct site value load
  input  wire                          site_wr,
  input  wire [`HSSE_IDX_W-1:0]        site_idx,
  input  wire signed [`HSSE_VAL_W-1:0] site_data,
  // Site value setup from edge deltas
  input  wire                          setup_start,
  input  wire signed [`HSSE_DIFF_W-1:0] setup_dx,
  input  wire signed [`HSSE_DIFF_W-1:0] setup_dy,
  output wire                          setup_busy,
  // Update array constant
  input  wire                          eval_valid,
  input  wire signed [`HSSE_VAL_W-1:0] eval_const,
  output wire                          eval_ready,
  // Side results, one per site, named side_<ysite><xsite>
  output wire                          side_00,
  output wire                          side_01,
  output wire                          side_02,
  output wire                          side_03,
  output wire                          side_10,
  output wire                          side_11,
  output wire                          side_12,
  output wire                          side_13,
  output wire                          side_20,
  output wire                          side_21,
  output wire                          side_22,
  output wire                          side_23,
  output wire                          side_30,
  output wire                          side_31,
  output wire                          side_32,
  output wire                          side_33,
  output reg                           side_valid
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [1:0]                    state_reg;
  reg  [1:0]                    state_next;
  reg  [1:0]                    step_reg;
  reg  signed [`HSSE_DIFF_W-1:0] dx_reg;
  reg  signed [`HSSE_DIFF_W-1:0] dy_reg;
  // Column products dx*offsety and row products dy*offsetx
  reg  signed [`HSSE_VAL_W-1:0] ty_reg [0:`HSSE_AXIS-1];
  reg  signed [`HSSE_VAL_W-1:0] tx_reg [0:`HSSE_AXIS-1];
  wire signed [`HSSE_VAL_W-1:0] dx8_w;
  wire signed [`HSSE_VAL_W-1:0] dy8_w;
  wire                          build_load_w;
  wire                          eval_take_w;
  wire [`HSSE_SITES-1:0]        sign_w;
  wire [`HSSE_SITES-1:0]        wr_sel_w;
  integer                       k;

  // --------------------------------------------------------------------------
  // Handshake
  // --------------------------------------------------------------------------
  // Site registers change during setup, so evaluation waits for it
  assign setup_busy   = (state_reg != `HSSE_ST_IDLE);
  assign eval_ready   = ~setup_busy;
  assign eval_take_w  = eval_valid & eval_ready;
  assign build_load_w = (state_reg == `HSSE_ST_LOAD);
  // One-hot site select keeps the index compare out of the generate loop
  assign wr_sel_w     = {{(`HSSE_SITES-1){1'b0}}, 1'b1} << site_idx;

  // --------------------------------------------------------------------------
  // Eight times dx and dy by a left shift of three
  // --------------------------------------------------------------------------
  // Offsets 0, 8, 16, 24 are whole pixels sampled at the corner
  assign dx8_w = {{(`HSSE_VAL_W-`HSSE_DIFF_W-`HSSE_OFS_SHIFT){dx_reg[`HSSE_DIFF_W-1]}},
                  dx_reg, {`HSSE_OFS_SHIFT{1'b0}}};
  assign dy8_w = {{(`HSSE_VAL_W-`HSSE_DIFF_W-`HSSE_OFS_SHIFT){dy_reg[`HSSE_DIFF_W-1]}},
                  dy_reg, {`HSSE_OFS_SHIFT{1'b0}}};

  // --------------------------------------------------------------------------
  // Setup sequencer
  // --------------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `HSSE_ST_IDLE: begin
        if (setup_start) begin
          state_next = `HSSE_ST_BUILD;
        end
      end
      `HSSE_ST_BUILD: begin
        if (step_reg == `HSSE_STEP_LAST) begin
          state_next = `HSSE_ST_LOAD;
        end
      end
      `HSSE_ST_LOAD: begin
        state_next = `HSSE_ST_IDLE;
      end
      default: begin
        state_next = `HSSE_ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_reg <= `HSSE_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Product tables, once per edge
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      step_reg <= `HSSE_STEP_FIRST;
      dx_reg   <= {`HSSE_DIFF_W{1'b0}};
      dy_reg   <= {`HSSE_DIFF_W{1'b0}};
      for (k = 0; k < `HSSE_AXIS; k = k + 1) begin
        ty_reg[k] <= `HSSE_VAL_ZERO;
        tx_reg[k] <= `HSSE_VAL_ZERO;
      end
    end else if (state_reg == `HSSE_ST_IDLE) begin
      if (setup_start) begin
        // Deltas are differences of signed 16-bit subpixel coordinates
        dx_reg    <= setup_dx;
        dy_reg    <= setup_dy;
        ty_reg[0] <= `HSSE_VAL_ZERO;
        tx_reg[0] <= `HSSE_VAL_ZERO;
        step_reg  <= `HSSE_STEP_FIRST;
      end
    end else if (state_reg == `HSSE_ST_BUILD) begin
      ty_reg[step_reg] <= ty_reg[step_reg - `HSSE_STEP_FIRST] + dx8_w;
      tx_reg[step_reg] <= tx_reg[step_reg - `HSSE_STEP_FIRST] + dy8_w;
      step_reg         <= step_reg + `HSSE_STEP_FIRST;
    end
  end

  // --------------------------------------------------------------------------
  // Site cells
  // --------------------------------------------------------------------------
  // Index is ysite*4 + xsite; the constant bus fans out unchanged
  genvar gi;
  generate
    for (gi = 0; gi < `HSSE_SITES; gi = gi + 1) begin : g_site
      wire                          dir_wr_w;
      wire                          load_w;
      wire signed [`HSSE_VAL_W-1:0] built_w;
      wire signed [`HSSE_VAL_W-1:0] val_w;

      // Direct writes are ignored while setup owns the registers
      assign dir_wr_w = site_wr & ~setup_busy
                      & wr_sel_w[gi];
      assign load_w   = dir_wr_w | build_load_w;
      // Offset pair (xsite, ysite) picks its table entries
      assign built_w  = ty_reg[gi / `HSSE_AXIS]
                      - tx_reg[gi % `HSSE_AXIS];
      assign val_w    = build_load_w ? built_w : site_data;

      hsse_site_cell u_cell (
        .mclk      (mclk),
        .rst       (rst),
        .load_en   (load_w),
        .load_val  (val_w),
        .eval_en   (eval_take_w),
        .const_val (eval_const),
        .sign_out  (sign_w[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Result strobe
  // --------------------------------------------------------------------------
  // Each taken constant is one update array; tiling order is the caller's
  always @(posedge mclk) begin
    if (rst) begin
      side_valid <= 1'b0;
    end else begin
      side_valid <= eval_take_w;
    end
  end

  // --------------------------------------------------------------------------
  // Separate side outputs
  // --------------------------------------------------------------------------
  assign side_00 = sign_w[0];
  assign side_01 = sign_w[1];
  assign side_02 = sign_w[2];
  assign side_03 = sign_w[3];
  assign side_10 = sign_w[4];
  assign side_11 = sign_w[5];
  assign side_12 = sign_w[6];
  assign side_13 = sign_w[7];
  assign side_20 = sign_w[8];
  assign side_21 = sign_w[9];
  assign side_22 = sign_w[10];
  assign side_23 = sign_w[11];
  assign side_30 = sign_w[12];
  assign side_31 = sign_w[13];
  assign side_32 = sign_w[14];
  assign side_33 = sign_w[15];

endmodule // hsse_evaluator

`default_nettype wire

// File: hsse_eval_assertions.sv
// Port timing checker for hsse_evaluator.
// Assumes binding to the design top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "hsse_defines.vh"
module hsse_eval_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Handshakes
  input wire logic setup_start,
  input wire logic setup_busy,
  input wire logic eval_valid,
  input wire logic eval_ready,
  // Results
  input wire logic side_00,
  input wire logic side_01,
  input wire logic side_02,
  input wire logic side_03,
  input wire logic side_10,
  input wire logic side_11,
  input wire logic side_12,
  input wire logic side_13,
  input wire logic side_20,
  input wire logic side_21,
  input wire logic side_22,
  input wire logic side_23,
  input wire logic side_30,
  input wire logic side_31,
  input wire logic side_32,
  input wire logic side_33,
  input wire logic side_valid
);
  wire [15:0] sides = {side_33, side_32, side_31, side_30, side_23, side_22, side_21, side_20,
                       side_13, side_12, side_11, side_10, side_03, side_02, side_01, side_00};
  wire        take  = eval_valid && eval_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_valid_after_take: assert property (take |=> side_valid)
    else $error("no result strobe after a taken constant");
  chk_valid_needs_take: assert property (side_valid |-> $past(take))
    else $error("result strobe without a taken constant");
  chk_ready_not_busy: assert property (eval_ready == !setup_busy)
    else $error("ready does not mirror busy");
  chk_busy_four_cycles: assert property ($rose(setup_busy) |-> setup_busy[*4] ##1 !setup_busy)
    else $error("setup busy length wrong");
  chk_start_sets_busy: assert property (setup_start && !setup_busy |=> setup_busy)
    else $error("setup start not taken");
  chk_busy_has_start: assert property ($rose(setup_busy) |-> $past(setup_start))
    else $error("busy without setup start");
  chk_sides_change_strobed: assert property (!$stable(sides) |-> side_valid)
    else $error("sides changed without strobe");
  chk_busy_blocks_eval: assert property (setup_busy |=> !side_valid)
    else $error("evaluation taken while busy");
  cover property (take ##1 take);
  cover property ($rose(setup_busy));
  cover property (eval_valid && !eval_ready);
endmodule // hsse_eval_checker
bind hsse_evaluator hsse_eval_checker u_chk (.*);
`default_nettype wire

// File: hsse_ctrl_model.sv
// Controller model: forms the half-space constant and offers it.
// Assumes go is pulsed just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hsse_ctrl_model (
  // Edge and origin request
  input  wire logic               mclk,
  input  wire logic               go,
  input  wire logic signed [35:0] dx,
  input  wire logic signed [35:0] dy,
  input  wire logic signed [35:0] ox,
  input  wire logic signed [35:0] oy,
  input  wire logic signed [35:0] x1,
  input  wire logic signed [35:0] y1,
  // Constant bus
  input  wire logic               eval_ready,
  output var  logic               eval_valid,
  output var  logic signed [35:0] eval_const
);
  initial eval_valid = 1'b0;
  initial eval_const = 36'h0;
  always @(posedge mclk) begin
    if (go) begin
      eval_valid <= 1'b1;
      eval_const <= dx * oy - dy * ox - dx * y1 + dy * x1;
    end else if (eval_valid && eval_ready) begin
      eval_valid <= 1'b0;
      // Released bus carries junk, not the old value
      eval_const <= ~eval_const;
    end
  end
endmodule // hsse_ctrl_model
`default_nettype wire

// File: hsse_testbench.sv
// Self-checking bench for hsse_evaluator.
// Assumes hsse_ctrl_model drives the constant bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               mclk, rst, site_wr, setup_start, go;
  logic [3:0]         site_idx;
  logic signed [35:0] site_data, m_dx, m_dy, m_ox, m_oy, m_x1, m_y1;
  logic signed [16:0] setup_dx, setup_dy;
  wire                eval_valid, eval_ready, setup_busy, side_valid;
  wire signed [35:0]  eval_const;
  wire [15:0]         sides;
  longint             v [16];
  int                 mismatches = 0, n_tests = 0, cyc = 0;
  hsse_evaluator u_dut (.mclk(mclk), .rst(rst), .site_wr(site_wr), .site_idx(site_idx),
    .site_data(site_data), .setup_start(setup_start), .setup_dx(setup_dx),
    .setup_dy(setup_dy), .setup_busy(setup_busy), .eval_valid(eval_valid),
    .eval_const(eval_const), .eval_ready(eval_ready), .side_valid(side_valid),
    .side_00(sides[0]), .side_01(sides[1]), .side_02(sides[2]), .side_03(sides[3]),
    .side_10(sides[4]), .side_11(sides[5]), .side_12(sides[6]), .side_13(sides[7]),
    .side_20(sides[8]), .side_21(sides[9]), .side_22(sides[10]), .side_23(sides[11]),
    .side_30(sides[12]), .side_31(sides[13]), .side_32(sides[14]), .side_33(sides[15]));
  hsse_ctrl_model u_ctrl (.mclk(mclk), .go(go), .dx(m_dx), .dy(m_dy), .ox(m_ox), .oy(m_oy),
    .x1(m_x1), .y1(m_y1), .eval_ready(eval_ready), .eval_valid(eval_valid),
    .eval_const(eval_const));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_vec(input longint c);
    for (int i = 0; i < 16; i++) exp_vec[i] = (v[i] + c) < 0;
  endfunction
  task automatic offer(input longint dx, dy, ox, oy, x1, y1);
    {m_dx, m_dy, m_ox, m_oy, m_x1, m_y1} = {dx[35:0], dy[35:0], ox[35:0], oy[35:0],
                                            x1[35:0], y1[35:0]};
    go = 1'b1;
  endtask
  task automatic t_reset;
    rst = 1'b1;
    repeat (20) tick;
    rst = 1'b0;
    check("reset_state", {sides, side_valid, setup_busy, eval_ready}, 36'h1);
  endtask
  // Constant offered during setup: must wait for the loaded sites
  task automatic t_setup(input longint dx, dy, ox, oy, x1, y1);
    int n;
    n = 0;
    for (int i = 0; i < 16; i++) v[i] = 8 * dx * (i / 4) - 8 * dy * (i % 4);
    {setup_dx, setup_dy} = {dx[16:0], dy[16:0]};
    setup_start = 1'b1;
    tick;
    // Start, new deltas and direct writes while busy must all be refused
    {setup_dx, setup_dy} = {dy[16:0], dx[16:0]};
    {site_wr, site_idx, site_data} = {1'b1, 4'h0, 36'h7FFFFFFFF};
    offer(dx, dy, ox, oy, x1, y1);
    while (setup_busy === 1'b1 && n < 20) begin
      tick;
      go = 1'b0;
      n++;
    end
    {setup_start, site_wr} = 2'h0;
    check("busy_cycles", n, 4);
    check("valid_early", side_valid, 0);
    tick;
    check("valid", side_valid, 1);
    check("sides", sides, exp_vec(dx * oy - dy * ox - dx * y1 + dy * x1));
  endtask
  // Direct loads with extreme values, then three constants back to back
  task automatic t_direct;
    longint cs [3] = '{0, -1, 1};
    for (int i = 0; i < 16; i++) v[i] = (i % 2) ? i / 2 : -(i / 2);
    v[14] = -36'sh7FFFFFFFF - 1;
    v[15] = 36'sh7FFFFFFFF;
    for (int i = 0; i < 16; i++) begin
      {site_wr, site_idx, site_data} = {1'b1, i[3:0], v[i][35:0]};
      tick;
    end
    site_wr = 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (k < 3) offer(1, 0, 0, cs[k], 0, 0);
      else go = 1'b0;
      tick;
      if (k >= 1 && k <= 3) check("sides_b2b", sides, exp_vec(cs[k - 1]));
      check("valid_b2b", side_valid, k >= 1 && k <= 3);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      summarize;
    end
  end
  initial begin
    {rst, site_wr, setup_start, go, site_idx} = 8'h80;
    {site_data, setup_dx, setup_dy} = 70'h0;
    {m_dx, m_dy, m_ox, m_oy, m_x1, m_y1} = 216'h0;
    #1;
    t_reset;
    t_setup(40, 24, 0, 0, 4, 3);
    t_setup(8, 8, 0, 0, 0, 0);
    t_setup(-100, 300, 16, -32, -5, 7);
    t_setup(65535, -65536, -32768, 32767, 32767, -32768);
    t_direct;
    t_reset;
    summarize;
  end
endmodule // testbench
`default_nettype wire
